// ---- inc/dcef_pkg.sv ----
// Package: register map, flag positions and reset values for the channel event flags
package dcef_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] DCEF_EVENT_OFF = 4'h0;
  localparam logic [3:0] DCEF_MASK_OFF = 4'h4;
  localparam logic [3:0] DCEF_CFG_OFF = 4'h8;
  // ----------------------------------------
  // Flag positions
  // ----------------------------------------
  localparam int DCEF_ERR_BIT = 0;
  localparam int DCEF_ABORT_BIT = 1;
  localparam int DCEF_CELL_BIT = 2;
  localparam int DCEF_BLOCK_BIT = 3;
  localparam int DCEF_HALF_BIT = 4;
  localparam int DCEF_NFLAGS = 5;
  // ----------------------------------------
  // Config field positions and reset values
  // ----------------------------------------
  localparam int DCEF_CFG_AIRQ_LSB = 0;
  localparam int DCEF_CFG_AEN_BIT = 8;
  localparam logic [4:0] DCEF_FLAGS_RST = 5'h00;
  localparam logic [4:0] DCEF_MASK_RST = 5'h00;
  localparam logic [7:0] DCEF_AIRQ_RST = 8'hFF;
  localparam logic DCEF_AEN_RST = 1'b0;
  typedef logic [4:0] dcef_flags_t;
endpackage

// ---- inc/dcef_evt_if.sv ----
// Interface: one event line into a sticky flag and the software clear
`timescale 1ns/100ps
`default_nettype none
interface dcef_evt_if;
  logic set;
  logic clr;
  logic flag;
  modport src (output set, output clr, input flag);
  modport dst (input set, input clr, output flag);
endinterface
`default_nettype wire

// ---- rtl/dcef_flag.sv ----
// Module: one sticky event flag, set wins over a software clear
`timescale 1ns/100ps
`default_nettype none
module dcef_flag (
  input wire logic sys_clk,
  input wire logic rst_n,
  dcef_evt_if.dst ev
);
  logic flag_q;
  logic flag_d;
  // Set wins so an event in the clearing cycle is not lost
  assign flag_d = ev.set | (flag_q & ~ev.clr);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
  assign ev.flag = flag_q;
  sticky_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flag_q && !ev.clr |=> flag_q) else $error("flag dropped without clear");
  set_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev.set |=> flag_q) else $error("event lost");
endmodule
`default_nettype wire

// ---- rtl/dcef_top.sv ----
// Module: DMA channel event flags with Wishbone register access
//
// Behaviour
// - Half-full when dest pointer equals half size
// - Block done when larger size bytes moved
// - Pattern match also sets block done
// - Cell done each cell size bytes moved
// - Matching abort irq aborts, sets abort flag
// - Invalid source or destination sets error
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dcef_top
  import dcef_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] dest_pointer,
  input wire logic [15:0] dest_size,
  input wire logic [15:0] source_size,
  input wire logic [15:0] cell_size,
  input wire logic [15:0] block_count,
  input wire logic [15:0] cell_count,
  input wire logic xfer_step,
  input wire logic pattern_match,
  input wire logic [255:0] irq_lines,
  input wire logic src_addr_err,
  input wire logic dst_addr_err,
  output logic abort_req,
  output logic irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [DCEF_NFLAGS-1:0] mask_q;
  logic [7:0] airq_q;
  logic aen_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic abort_q;
  logic irq_q;
  logic [DCEF_NFLAGS-1:0] flags;
  logic [DCEF_NFLAGS-1:0] set_vec;
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire hit_evt = (wb_adr_i[3:0] == DCEF_EVENT_OFF);
  wire hit_mask = (wb_adr_i[3:0] == DCEF_MASK_OFF);
  wire hit_cfg = (wb_adr_i[3:0] == DCEF_CFG_OFF);
  wire [DCEF_NFLAGS-1:0] clr_vec = (bus_wr && hit_evt) ? wb_dat_i[DCEF_NFLAGS-1:0] : '0;
  // Next flag and mask values, so the interrupt flop never lags a write
  wire [DCEF_NFLAGS-1:0] flags_d = set_vec | (flags & ~clr_vec);
  wire [DCEF_NFLAGS-1:0] mask_d = (bus_wr && hit_mask) ? wb_dat_i[DCEF_NFLAGS-1:0] : mask_q;
  logic [31:0] rdat_d;
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (hit_evt) begin
      rdat_d[DCEF_NFLAGS-1:0] = flags;
    end else if (hit_mask) begin
      rdat_d[DCEF_NFLAGS-1:0] = mask_q;
    end else if (hit_cfg) begin
      rdat_d[DCEF_CFG_AIRQ_LSB +: 8] = airq_q;
      rdat_d[DCEF_CFG_AEN_BIT] = aen_q;
    end
  end
  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  // Sizes assumed nonzero; a zero size would fire on every step
  wire [15:0] half_size = {1'b0, dest_size[15:1]};
  wire [15:0] big_size = (source_size > dest_size) ? source_size : dest_size;
  wire half_ev = xfer_step && (dest_pointer == half_size);
  wire block_ev = (xfer_step && (block_count == big_size)) | pattern_match;
  wire cell_ev = xfer_step && (cell_count == cell_size);
  wire abort_ev = aen_q && irq_lines[airq_q];
  wire err_ev = src_addr_err | dst_addr_err;
  assign set_vec = {half_ev, block_ev, cell_ev, abort_ev, err_ev};
  // ----------------------------------------
  // Sticky flags
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DCEF_NFLAGS; gi++) begin : g_flag
      dcef_evt_if ev ();
      assign ev.set = set_vec[gi];
      assign ev.clr = clr_vec[gi];
      assign flags[gi] = ev.flag;
      dcef_flag u_flag (.sys_clk(sys_clk), .rst_n(rst_n), .ev(ev));
    end
  endgenerate
  // ----------------------------------------
  // Clocked state
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask_q <= DCEF_MASK_RST;
      airq_q <= DCEF_AIRQ_RST;
      aen_q <= DCEF_AEN_RST;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      abort_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
      rdat_q <= bus_req ? rdat_d : 32'h0000_0000;
      mask_q <= mask_d;
      if (bus_wr && hit_cfg) begin
        airq_q <= wb_dat_i[DCEF_CFG_AIRQ_LSB +: 8];
        aen_q <= wb_dat_i[DCEF_CFG_AEN_BIT];
      end
      // Abort request follows the abort flag; a clear while the source is high re-arms it
      abort_q <= abort_ev | (abort_q & ~clr_vec[DCEF_ABORT_BIT]);
      irq_q <= |(flags_d & mask_d);
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign abort_req = abort_q;
  assign irq = irq_q;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Registered answer: one wait state, then ack for a single cycle
  sequence bus_take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence bus_answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // Abort: source seen, then flag and request together
  sequence abort_hit_s;
    aen_q && irq_lines[airq_q];
  endsequence
  sequence abort_out_s;
    flags[DCEF_ABORT_BIT] && abort_req;
  endsequence
  sequence abort_clear_s;
    clr_vec[DCEF_ABORT_BIT] && !abort_ev;
  endsequence
  half_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xfer_step && dest_pointer == half_size |=> flags[DCEF_HALF_BIT])
    else $error("half-full flag missed");
  half_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !xfer_step && !flags[DCEF_HALF_BIT] |=> !flags[DCEF_HALF_BIT])
    else $error("half-full flag without a step");
  block_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xfer_step && block_count == big_size |=> flags[DCEF_BLOCK_BIT])
    else $error("block flag missed");
  pattern_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pattern_match |=> flags[DCEF_BLOCK_BIT]) else $error("pattern match missed");
  cell_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xfer_step && cell_count == cell_size |=> flags[DCEF_CELL_BIT])
    else $error("cell flag missed");
  cell_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !xfer_step && !flags[DCEF_CELL_BIT] |=> !flags[DCEF_CELL_BIT])
    else $error("cell flag without a step");
  abort_seen_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    abort_hit_s |=> abort_out_s)
    else $error("abort missed");
  abort_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    abort_req && !clr_vec[DCEF_ABORT_BIT] |=> abort_req)
    else $error("abort request dropped early");
  abort_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    abort_clear_s |=> !abort_req && !flags[DCEF_ABORT_BIT])
    else $error("abort request held after clear");
  // Abort enable off keeps the channel running whatever the lines do
  abort_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !aen_q && !abort_req |=> !abort_req)
    else $error("abort while disabled");
  cfg_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_wr && hit_cfg |=> airq_q == $past(wb_dat_i[DCEF_CFG_AIRQ_LSB +: 8])
      && aen_q == $past(wb_dat_i[DCEF_CFG_AEN_BIT]))
    else $error("abort select write lost");
  addr_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    src_addr_err || dst_addr_err |=> flags[DCEF_ERR_BIT]) else $error("error missed");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(flags[DCEF_CELL_BIT]) |-> $past(clr_vec[DCEF_CELL_BIT]))
    else $error("flag fell without clear");
  // Every flag: a clear with no event empties it, no event keeps it empty
  genvar gc;
  generate
    for (gc = 0; gc < DCEF_NFLAGS; gc++) begin : g_chk
      clear_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clr_vec[gc] && !set_vec[gc] |=> !flags[gc])
        else $error("flag kept after clear");
      raise_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !flags[gc] && !set_vec[gc] |=> !flags[gc])
        else $error("flag rose without event");
    end
  endgenerate
  // ----------------------------------------
  // Bus and interrupt checks
  // ----------------------------------------
  irq_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq == |(flags & mask_q)) else $error("interrupt does not follow flags");
  ack_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  bus_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_take_s |=> bus_answer_s)
    else $error("bus request not answered in one cycle");
  read_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside acknowledge");
  evt_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req && !wb_we_i && hit_evt |=> wb_dat_o[DCEF_NFLAGS-1:0] == $past(flags))
    else $error("flag read mismatch");
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req && !hit_evt && !hit_mask && !hit_cfg |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  mask_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_wr && hit_mask |=> mask_q == $past(wb_dat_i[DCEF_NFLAGS-1:0]))
    else $error("mask write lost");
  sel_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req && !wb_sel_i[0] |=> $stable(mask_q) && $stable(airq_q) && $stable(aen_q))
    else $error("write without byte select");
  reset_state_a: assert property (@(posedge sys_clk)
    !rst_n |=> !wb_ack_o && !irq && !abort_req && flags == '0 && mask_q == DCEF_MASK_RST)
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ---- test/dcef_eng_model.sv ----
// Partner: transfer engine counters and interrupt sources of one channel
`timescale 1ns/100ps
`default_nettype none
module dcef_eng_model (
  input wire logic sys_clk,
  output logic [15:0] dest_pointer,
  output logic [15:0] dest_size,
  output logic [15:0] source_size,
  output logic [15:0] cell_size,
  output logic [15:0] block_count,
  output logic [15:0] cell_count,
  output logic xfer_step,
  output logic pattern_match,
  output logic [255:0] irq_lines,
  output logic src_addr_err,
  output logic dst_addr_err
);
  // Idle never meets a compare: sizes stay at 16 or more, counts at 0
  initial begin
    {dest_size, source_size, cell_size, dest_pointer} = {4{16'h0010}};
    {block_count, cell_count, xfer_step, pattern_match} = '0;
    {irq_lines, src_addr_err, dst_addr_err} = '0;
  end
  // One engine step of kind k, then back to idle
  task automatic fire(input int k, input logic [7:0] sel);
    logic [15:0] s;
    logic [15:0] d;
    s = 16'($urandom) | 16'h0010;
    d = 16'($urandom) | 16'h0010;
    source_size <= s;
    cell_size <= s;
    dest_size <= d;
    dest_pointer <= (k == 0) ? d >> 1 : d;
    block_count <= (k == 2) ? ((s > d) ? s : d) : 16'h0000;
    cell_count <= (k == 1) ? s : 16'h0000;
    xfer_step <= (k < 3);
    pattern_match <= (k == 3);
    irq_lines <= (k == 4) ? 256'h1 << sel : '0;
    src_addr_err <= (k == 5);
    dst_addr_err <= (k == 6);
    @(posedge sys_clk);
    dest_pointer <= d;
    {block_count, cell_count} <= '0;
    {xfer_step, pattern_match, irq_lines, src_addr_err, dst_addr_err} <= '0;
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Testbench: event flags, mask and interrupt over Wishbone
`timescale 1ns/100ps
`default_nettype none
module testbench import dcef_pkg::*;;
  logic sys_clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'hF;
  logic wb_ack_o, abort_req, irq, xfer_step, pattern_match, src_addr_err, dst_addr_err;
  logic [15:0] dest_pointer, dest_size, source_size, cell_size, block_count, cell_count;
  logic [255:0] irq_lines;
  logic [7:0] sel;
  logic [4:0] m;
  int k, miscompares = 0, tests_run = 0;
  localparam int BITS [7] = '{DCEF_HALF_BIT, DCEF_CELL_BIT, DCEF_BLOCK_BIT, DCEF_BLOCK_BIT,
    DCEF_ABORT_BIT, DCEF_ERR_BIT, DCEF_ERR_BIT};
  dcef_top DUT (.sys_clk, .rst_n, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .dest_pointer, .dest_size, .source_size, .cell_size,
    .block_count, .cell_count, .xfer_step, .pattern_match, .irq_lines, .src_addr_err,
    .dst_addr_err, .abort_req, .irq);
  dcef_eng_model eng (.sys_clk, .dest_pointer, .dest_size, .source_size, .cell_size,
    .block_count, .cell_count, .xfer_step, .pattern_match, .irq_lines, .src_addr_err,
    .dst_addr_err);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] exp_flag(input int kind);
    return 32'h1 << BITS[kind];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // No fixed answer time is assumed; the watchdog guards a dead bus
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, 28'h0, a, d};
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge sys_clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial forever #50 sys_clk = ~sys_clk;
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h9f6f2118));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    wb(0, DCEF_CFG_OFF, 0);
    chk(q, 32'h0000_00FF);
    wb(1, 4'hC, '1);
    wb(0, 4'hC, 0);
    chk(q, 32'h0);
    wb_sel_i <= 4'hE;
    wb(1, DCEF_MASK_OFF, '1);
    wb_sel_i <= 4'hF;
    wb(0, DCEF_MASK_OFF, 0);
    chk(q, 32'h0);
    eng.fire(4, DCEF_AIRQ_RST);
    repeat (2) @(posedge sys_clk);
    wb(0, DCEF_EVENT_OFF, 0);
    chk(q | {31'h0, abort_req}, 32'h0);
    sel = 8'($urandom);
    wb(1, DCEF_CFG_OFF, {23'h0, 1'b1, sel});
    for (int i = 0; i < 14; i++) begin
      k = i % 7;
      m = 5'($urandom);
      wb(1, DCEF_MASK_OFF, {27'h0, m});
      eng.fire(k, sel);
      repeat (3) @(posedge sys_clk);
      chk({31'h0, irq}, {31'h0, |(exp_flag(k) & {27'h0, m})});
      chk({31'h0, abort_req}, {31'h0, k == 4});
      wb(0, DCEF_EVENT_OFF, 0);
      chk(q, exp_flag(k));
      wb(1, DCEF_EVENT_OFF, exp_flag(k));
      wb(0, DCEF_EVENT_OFF, 0);
      chk(q | {31'h0, abort_req}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("test %0d kind %0d done", i, k);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
